// ==== hw/pcp_regs_map.svh ====
// Register offsets, field positions and reset values of the configuration page bank
`ifndef PCP_REGS_MAP_SVH
`define PCP_REGS_MAP_SVH
`define PCP_OFS_PULL      10'h145
`define PCP_OFS_ROUTE     10'h146
`define PCP_OFS_OSC       10'h147
`define PCP_OFS_ALTADDR   10'h148
`define PCP_OFS_PAGE      10'h200
`define PCP_OFS_DEVID     10'h201
`define PCP_OFS_REVVAR    10'h202
`define PCP_OFS_CUSTID    10'h203
`define PCP_OFS_OTPID     10'h204
`define PCP_PULL_MASK     8'h1f
`define PCP_OSC_MASK      8'h87
`define PCP_ALT_MASK      8'hf3
`define PCP_PAGE_MASK     8'hc7
`define PCP_RST_PULL      8'h00
`define PCP_RST_ROUTE     8'h00
`define PCP_RST_OSC       8'h00
`define PCP_RST_ALT       8'h00
`define PCP_RST_PAGE      8'h00
`define PCP_BIT_PAGE_AUTO_RETURN    7
`define PCP_BIT_WMODE     6
`define PCP_BIT_STALONE   7
`define PCP_BIT_P_IN4     4
`define PCP_BIT_P_PIN3    3
`define PCP_BIT_P_PIN2    2
`define PCP_BIT_P_IN1     1
`define PCP_BIT_P_IN0     0
`define PCP_PAGE_ZERO     3'h0
`define PCP_NIB_BLANK     4'h0
`define PCP_NIB_ZERO      4'h0
`define PCP_OSC_STEP_KHZ  12'd180
`define PCP_WIN_SHIFT     7
`define PCP_LSB_TWO_WIRE  8'hff
`define PCP_TW_OFS_MASK   8'hff
`define PCP_FW_OFS_MASK   8'h7f
`define PCP_WIN_OFS_PAGE  8'h00
`endif

// ==== hw/pcp_pkg.sv ====
// Types shared by the configuration page bank
package pcp_pkg;
  typedef enum logic [1:0] {
    PCP_ROUTE_NONE = 2'h0,
    PCP_ROUTE_PIN2 = 2'h1,
    PCP_ROUTE_PIN3 = 2'h2,
    PCP_ROUTE_RSVD = 2'h3
  } pcp_route_t;
  typedef enum logic [1:0] {
    PCP_ASEL_NONE = 2'h0,
    PCP_ASEL_IN0  = 2'h1,
    PCP_ASEL_IN1  = 2'h2,
    PCP_ASEL_IN4  = 2'h3
  } pcp_asel_t;
  typedef enum logic [1:0] {
    PCP_ST_IDLE = 2'b00,
    PCP_ST_BUSY = 2'b01,
    PCP_ST_DONE = 2'b11
  } pcp_state_t;
endpackage

// ==== hw/pcp_config_regs.sv ====
// Configuration, page-control and identity register bank
`timescale 1ns/10ps
`include "pcp_regs_map.svh"
// ============================================================
// How it works
// - Input pin pull-down follows its bit
// - Bidirectional pins: pull-down input, pull-up output
// - Power-good routing fields select output pin
// - Ready routing fields select output pin
// - Bit seven chooses companion or stand-alone
// - Oscillator trim adds 180 kHz per code
// - Upper nibble forms second base address
// - Slave address offsets select page pairs
// - Blank nibble falls back to default address
// - Field picks pin selecting alternate address
// - Auto return clears page after access
// - Bit six picks page or repeated write
// - Two-wire page map ignores page bit zero
// - Four-wire page map uses 128-register windows
// - Interface type bit; four-wire claims pins
module pcp_config_regs #(
  parameter logic [6:0] DEFAULT_ADDR7 = 7'h68,  // Hardware default address, upper seven bits
  parameter logic [7:0] DEVICE_CODE   = 8'h5a,  // Arbitrary identity value
  parameter logic [3:0] MASK_REV      = 4'h1,   // Arbitrary identity value
  parameter logic [3:0] CHIP_VARIANT  = 4'h2,   // Arbitrary identity value
  parameter logic [7:0] CUSTOMER_CODE = 8'h33,  // Arbitrary identity value
  parameter logic [7:0] OTP_VARIANT   = 8'h44   // Arbitrary identity value
) (
  input  wire logic                core_clk_i,            // Core clock, 40 MHz
  input  wire logic                rst_i,                 // Synchronous reset, active high
  input  wire logic                acc_start_i,           // Serial access begins (pulse)
  input  wire logic                acc_done_i,            // Serial access completed (pulse)
  input  wire logic                wr_en_i,               // Register write strobe
  input  wire logic                rd_en_i,               // Register read strobe
  input  wire logic [7:0]          local_addr_i,          // Address inside the selected page window
  input  wire logic [7:0]          wr_data_i,             // Write data
  input  wire logic                four_wire_i,           // Interface type: 1 four-wire, 0 two-wire
  input  wire logic [6:0]          slave_addr7_i,         // Received two-wire address, upper 7 bits
  input  wire logic                input_pin_zero_i,      // Input pin zero level
  input  wire logic                input_pin_one_i,       // Input pin one level
  input  wire logic                input_pin_four_i,      // Input pin four level
  input  wire logic                pin_two_is_out_i,      // Pin two used as open-drain output
  input  wire logic                pin_three_is_out_i,    // Pin three used as open-drain output
  input  wire logic                rega_good_i,           // Regulator A power-good
  input  wire logic                regb_good_i,           // Regulator B power-good
  input  wire logic                rega_ready_i,          // Regulator A ready
  input  wire logic                regb_ready_i,          // Regulator B ready
  output logic [7:0]               rd_data_o,             // Read data, valid cycle after rd_en_i
  output logic                     addr_hit_o,            // Received address belongs to us
  output logic [2:0]               addr_page_o,           // Page picked by the received address
  output logic [9:0]               full_addr_o,           // Register address of current access
  output logic                     write_mode_o,          // 0 page write, 1 repeated write
  output logic                     input_zero_pull_dn_o,  // Pull-down on input zero
  output logic                     input_one_pull_dn_o,   // Pull-down on input one
  output logic                     input_four_pull_dn_o,  // Pull-down on input four
  output logic                     pin_two_pull_dn_o,     // Pull-down on pin two
  output logic                     pin_two_pull_up_o,     // Pull-up on pin two
  output logic                     pin_three_pull_dn_o,   // Pull-down on pin three
  output logic                     pin_three_pull_up_o,   // Pull-up on pin three
  output logic                     output_pin_two_o,      // Routed level for output pin two
  output logic                     output_pin_three_o,    // Routed level for output pin three
  output logic                     stand_alone_o,         // 1 stand-alone, 0 companion
  output logic [11:0]              osc_offset_khz_o,      // Oscillator raise in kHz
  output logic [2:0]               oscillator_trim_o,     // Oscillator trim code
  output logic [6:0]               active_base7_o         // Base address in use, upper 7 bits
);
  import pcp_pkg::*;

  // ============================================================
  // Register storage
  logic [7:0] pull_q, route_q, osc_q, alt_q, page_q;
  logic [7:0] pull_d, route_d, osc_d, alt_d, page_d;
  pcp_state_t st_q, st_d;
  logic [7:0] rd_data_q;

  // ============================================================
  // Address decode
  logic [2:0] page_sel;
  logic [9:0] full_addr;
  assign page_sel = page_q[2:0];
  // Two-wire: 256-register windows, page bit zero ignored
  wire [9:0] tw_addr = {page_sel[2:1], local_addr_i};
  // Four-wire: 128-register windows; codes 011 and above 100 alias nothing useful
  wire [9:0] fw_addr = {page_sel, local_addr_i[6:0]};
  assign full_addr = four_wire_i ? fw_addr : tw_addr;

  wire sel_pull  = (full_addr == `PCP_OFS_PULL);
  wire sel_route = (full_addr == `PCP_OFS_ROUTE);
  wire sel_osc   = (full_addr == `PCP_OFS_OSC);
  wire sel_alt   = (full_addr == `PCP_OFS_ALTADDR);
  // Page register also answers at offset zero of every window;
  // without it a host could never leave the page it is in
  wire [7:0] win_mask = four_wire_i ? `PCP_FW_OFS_MASK : `PCP_TW_OFS_MASK;
  wire       win_zero = ((local_addr_i & win_mask) == `PCP_WIN_OFS_PAGE);
  wire sel_page  = (full_addr == `PCP_OFS_PAGE) || win_zero;

  // ============================================================
  // Write path; identity registers have no storage so writes drop
  assign pull_d  = (wr_en_i && sel_pull)  ? (wr_data_i & `PCP_PULL_MASK) : pull_q;
  assign route_d = (wr_en_i && sel_route) ? wr_data_i : route_q;
  assign osc_d   = (wr_en_i && sel_osc)   ? (wr_data_i & `PCP_OSC_MASK) : osc_q;
  // Bits 3:2 are read-only reserved
  assign alt_d   = (wr_en_i && sel_alt)   ? (wr_data_i & `PCP_ALT_MASK) : alt_q;

  // Access tracker for the auto-return of the page
  always_comb begin
    st_d = st_q;
    case (st_q)
      PCP_ST_IDLE: if (acc_start_i) st_d = PCP_ST_BUSY;
      PCP_ST_BUSY: if (acc_done_i) st_d = PCP_ST_DONE;
      PCP_ST_DONE: st_d = acc_start_i ? PCP_ST_BUSY : PCP_ST_IDLE;
      default:     st_d = PCP_ST_IDLE;
    endcase
  end

  // Return happens at completion, so the write that set the bit still lands in the old page
  wire page_auto_return_now = page_q[`PCP_BIT_PAGE_AUTO_RETURN] && (st_q == PCP_ST_BUSY) && acc_done_i;
  logic [7:0] page_w;
  assign page_w = (wr_en_i && sel_page) ? (wr_data_i & `PCP_PAGE_MASK) : page_q;
  assign page_d = page_auto_return_now ? {page_w[7:3], `PCP_PAGE_ZERO} : page_w;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pull_q  <= `PCP_RST_PULL;
      route_q <= `PCP_RST_ROUTE;
      osc_q   <= `PCP_RST_OSC;
      alt_q   <= `PCP_RST_ALT;
      page_q  <= `PCP_RST_PAGE;
      st_q    <= PCP_ST_IDLE;
    end else begin
      pull_q  <= pull_d;
      route_q <= route_d;
      osc_q   <= osc_d;
      alt_q   <= alt_d;
      page_q  <= page_d;
      st_q    <= st_d;
    end
  end

  // ============================================================
  // Read path
  logic [7:0] rd_mux;
  always_comb begin
    if (sel_pull)                           rd_mux = pull_q;
    else if (sel_route)                     rd_mux = route_q;
    else if (sel_osc)                       rd_mux = osc_q;
    else if (sel_alt)                       rd_mux = alt_q;
    else if (sel_page)                      rd_mux = page_q;
    else if (full_addr == `PCP_OFS_DEVID)   rd_mux = DEVICE_CODE;
    else if (full_addr == `PCP_OFS_REVVAR)  rd_mux = {MASK_REV, CHIP_VARIANT};
    else if (full_addr == `PCP_OFS_CUSTID)  rd_mux = CUSTOMER_CODE;
    else if (full_addr == `PCP_OFS_OTPID)   rd_mux = OTP_VARIANT;
    else                                    rd_mux = 8'h00;
  end

  // ============================================================
  // Pin pull control
  wire p_in0 = pull_q[`PCP_BIT_P_IN0];
  wire p_in1 = pull_q[`PCP_BIT_P_IN1];
  wire p_in4 = pull_q[`PCP_BIT_P_IN4];
  wire p_pin2 = pull_q[`PCP_BIT_P_PIN2];
  wire p_pin3 = pull_q[`PCP_BIT_P_PIN3];

  // ============================================================
  // Routing; the reserved code is treated as no routing
  function automatic logic route_hit(input logic [1:0] f, input pcp_route_t tgt);
    route_hit = (pcp_route_t'(f) == tgt);
  endfunction
  wire [1:0] good_b_f  = route_q[7:6];
  wire [1:0] good_a_f  = route_q[5:4];
  wire [1:0] ready_b_f = route_q[3:2];
  wire [1:0] ready_a_f = route_q[1:0];
  wire out2 = (route_hit(good_b_f, PCP_ROUTE_PIN2) & regb_good_i) |
              (route_hit(good_a_f, PCP_ROUTE_PIN2) & rega_good_i) |
              (route_hit(ready_b_f, PCP_ROUTE_PIN2) & regb_ready_i) |
              (route_hit(ready_a_f, PCP_ROUTE_PIN2) & rega_ready_i);
  wire out3 = (route_hit(good_b_f, PCP_ROUTE_PIN3) & regb_good_i) |
              (route_hit(good_a_f, PCP_ROUTE_PIN3) & rega_good_i) |
              (route_hit(ready_b_f, PCP_ROUTE_PIN3) & regb_ready_i) |
              (route_hit(ready_a_f, PCP_ROUTE_PIN3) & rega_ready_i);

  // ============================================================
  // Address selection
  wire [3:0] base_nib = alt_q[7:4];
  wire       nib_blank = (base_nib == `PCP_NIB_BLANK);
  pcp_asel_t asel;
  assign asel = pcp_asel_t'(alt_q[1:0]);
  wire alt_pin = (asel == PCP_ASEL_IN0) ? input_pin_zero_i :
                 (asel == PCP_ASEL_IN1) ? input_pin_one_i :
                 (asel == PCP_ASEL_IN4) ? input_pin_four_i : 1'b0;
  wire use_alt = alt_pin && !nib_blank;
  wire [6:0] base7 = use_alt ? {base_nib, 3'h0} : DEFAULT_ADDR7;
  // Offset 0 page pair 0/1, 1 pair 2/3, 2 pair 4/5; larger offsets miss
  wire [6:0] addr_diff = slave_addr7_i - base7;
  wire       hit = (addr_diff <= 7'd2);
  wire [2:0] hit_page = {addr_diff[1:0], 1'b0};
  wire [11:0] osc_ofs = 12'(osc_q[2:0]) * `PCP_OSC_STEP_KHZ;

  // ============================================================
  // Output registers
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rd_data_q            <= 8'h00;
      addr_hit_o           <= 1'b0;
      addr_page_o          <= 3'h0;
      full_addr_o          <= 10'h000;
      write_mode_o         <= 1'b0;
      input_zero_pull_dn_o <= 1'b0;
      input_one_pull_dn_o  <= 1'b0;
      input_four_pull_dn_o <= 1'b0;
      pin_two_pull_dn_o    <= 1'b0;
      pin_two_pull_up_o    <= 1'b0;
      pin_three_pull_dn_o  <= 1'b0;
      pin_three_pull_up_o  <= 1'b0;
      output_pin_two_o     <= 1'b0;
      output_pin_three_o   <= 1'b0;
      stand_alone_o        <= 1'b0;
      osc_offset_khz_o     <= 12'h000;
      oscillator_trim_o    <= 3'h0;
      active_base7_o       <= 7'h00;
    end else begin
      if (rd_en_i) rd_data_q <= rd_mux;
      addr_hit_o           <= hit;
      addr_page_o          <= hit_page;
      full_addr_o          <= full_addr;
      write_mode_o         <= page_q[`PCP_BIT_WMODE];
      input_zero_pull_dn_o <= p_in0;
      input_one_pull_dn_o  <= p_in1;
      // Four-wire mode takes pin three and input four, so their pulls are released
      input_four_pull_dn_o <= p_in4 && !four_wire_i;
      pin_two_pull_dn_o    <= p_pin2 && !pin_two_is_out_i;
      pin_two_pull_up_o    <= p_pin2 && pin_two_is_out_i;
      pin_three_pull_dn_o  <= p_pin3 && !pin_three_is_out_i && !four_wire_i;
      pin_three_pull_up_o  <= p_pin3 && pin_three_is_out_i && !four_wire_i;
      output_pin_two_o     <= out2;
      output_pin_three_o   <= out3 && !four_wire_i;
      stand_alone_o        <= osc_q[`PCP_BIT_STALONE];
      osc_offset_khz_o     <= osc_ofs;
      oscillator_trim_o    <= osc_q[2:0];
      active_base7_o       <= base7;
    end
  end
  assign rd_data_o = rd_data_q;

  // ============================================================
  // Checks
  a_page_return: assert property (@(posedge core_clk_i) disable iff (rst_i)
    page_auto_return_now |=> (page_q[2:0] == `PCP_PAGE_ZERO)) else $error("page not returned");

  a_id_readonly: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (rd_en_i && full_addr == `PCP_OFS_DEVID) |=> (rd_data_o == DEVICE_CODE)) else $error("id mismatch");

  a_rd_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !rd_en_i |=> $stable(rd_data_o)) else $error("read data moved");

  a_pull_input: assert property (@(posedge core_clk_i) disable iff (rst_i)
    1'b1 |=> (input_zero_pull_dn_o == $past(pull_q[0]))) else $error("pull mismatch");

  a_pull_in4: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (pull_q[4] && !four_wire_i) |=> input_four_pull_dn_o) else $error("input four pull off");

  a_pull_both: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !(pin_two_pull_dn_o && pin_two_pull_up_o)) else $error("both pulls on");

  a_pull_three: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !(pin_three_pull_dn_o && pin_three_pull_up_o)) else $error("both pulls on pin three");

  a_pull_up_two: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (p_pin2 && pin_two_is_out_i) |=> pin_two_pull_up_o) else $error("pin two pull-up off");

  a_route_none: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (route_q == 8'h00) |=> !output_pin_two_o) else $error("route leak");

  a_good_route: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (route_q == 8'h10 && rega_good_i) |=> output_pin_two_o) else $error("good not routed");

  a_route_rsvd: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (route_q == 8'hff) |=> !(output_pin_two_o || output_pin_three_o)) else $error("reserved routed");

  a_ready_route: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (route_q == 8'h01 && rega_ready_i) |=> output_pin_two_o) else $error("ready not routed");

  a_ready_three: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (route_q == 8'h08 && regb_ready_i && !four_wire_i) |=> output_pin_three_o) else $error("ready b lost");

  a_osc_step: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (osc_q[2:0] == 3'h7) |=> (osc_offset_khz_o == 12'd1260)) else $error("osc offset wrong");

  a_trim_follow: assert property (@(posedge core_clk_i) disable iff (rst_i)
    1'b1 |=> (oscillator_trim_o == $past(osc_q[2:0]))) else $error("trim lag");

  a_blank_base: assert property (@(posedge core_clk_i) disable iff (rst_i)
    nib_blank |=> (active_base7_o == DEFAULT_ADDR7)) else $error("blank base used");

  a_no_alt_pin: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (asel == PCP_ASEL_NONE) |=> (active_base7_o == DEFAULT_ADDR7)) else $error("alt without pin");

  a_addr_base: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (slave_addr7_i == base7) |=> (addr_hit_o && addr_page_o == 3'h0)) else $error("base not hit");

  a_stand_alone: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $rose(osc_q[7]) |-> ##1 stand_alone_o) else $error("mode not followed");

  a_wmode_follow: assert property (@(posedge core_clk_i) disable iff (rst_i)
    1'b1 |=> (write_mode_o == $past(page_q[6]))) else $error("write mode lag");

  a_page_mirror: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (wr_en_i && win_zero && !page_auto_return_now) |=> (page_q == ($past(wr_data_i) & `PCP_PAGE_MASK)))
    else $error("page write lost");

  a_fw_window: assert property (@(posedge core_clk_i) disable iff (rst_i)
    four_wire_i |=> (full_addr_o[6:0] == $past(local_addr_i[6:0]))) else $error("window offset wrong");

  a_pin3_taken: assert property (@(posedge core_clk_i) disable iff (rst_i)
    four_wire_i |=> !(pin_three_pull_dn_o || pin_three_pull_up_o || output_pin_three_o))
    else $error("pin three not released");

  a_in4_taken: assert property (@(posedge core_clk_i) disable iff (rst_i)
    four_wire_i |=> !input_four_pull_dn_o) else $error("input four not released");

  c_page_auto_return: cover property (@(posedge core_clk_i) page_auto_return_now);
  c_alt_addr: cover property (@(posedge core_clk_i) use_alt && hit);
  c_fw_page: cover property (@(posedge core_clk_i) four_wire_i && page_sel == 3'h4 && rd_en_i);
  c_mirror_wr: cover property (@(posedge core_clk_i) wr_en_i && win_zero);
  c_in4_alt: cover property (@(posedge core_clk_i) asel == PCP_ASEL_IN4 && use_alt);
endmodule

// ==== verif/pcp_host_model.sv ====
// Host processor model driving the register strobes of the bank
`timescale 1ns/10ps
module pcp_host_model (
  input  wire logic       core_clk_i,   // Core clock
  output logic            wr_en_o,      // Write strobe
  output logic            rd_en_o,      // Read strobe
  output logic [7:0]      addr_o,       // In-window address
  output logic [7:0]      data_o,       // Write data
  output logic            acc_start_o,  // Serial access begins
  output logic            acc_done_o    // Serial access completed
);
  initial begin
    wr_en_o     = 1'b0;
    rd_en_o     = 1'b0;
    addr_o      = 8'h00;
    data_o      = 8'h00;
    acc_start_o = 1'b0;
    acc_done_o  = 1'b0;
  end
  // ============================================================
  // One strobe, held across the taking edge
  task automatic strobe(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    wr_en_o = wr;
    rd_en_o = ~wr;
    addr_o  = a;
    data_o  = d;
    @(negedge core_clk_i);
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    // Released lines carry garbage so stale values cannot pass
    addr_o  = ~a;
    data_o  = ~d;
  endtask
  task automatic pulse(input logic done);
    @(negedge core_clk_i);
    acc_start_o = ~done;
    acc_done_o  = done;
    @(negedge core_clk_i);
    acc_start_o = 1'b0;
    acc_done_o  = 1'b0;
  endtask
endmodule

// ==== verif/tb_top.sv ====
// Self-checking bench for the configuration page register bank
`timescale 1ns/10ps
module tb_top;
  import pcp_pkg::*;
  // ============================================================
  // Signals
  localparam logic [7:0] DEV = 8'hc1, CUST = 8'h3e, OTP = 8'h7d;  // Arbitrary identity values
  logic        core_clk_i = 1'b0, rst_i = 1'b1, four_wire_i = 1'b0, rd_d1 = 1'b0;
  logic        wr_en_i, rd_en_i, acc_start_i, acc_done_i;
  logic        input_pin_zero_i = 1'b0, input_pin_one_i = 1'b0, input_pin_four_i = 1'b0;
  logic        pin_two_is_out_i = 1'b0, pin_three_is_out_i = 1'b0;
  logic        rega_good_i = 1'b0, regb_good_i = 1'b0, rega_ready_i = 1'b0, regb_ready_i = 1'b0;
  logic [7:0]  local_addr_i, wr_data_i, rd_data_o, v;
  logic [6:0]  slave_addr7_i = 7'h00, active_base7_o, base, pe;
  logic [9:0]  full_addr_o;
  logic [11:0] osc_offset_khz_o;
  logic [2:0]  addr_page_o, oscillator_trim_o;
  logic [3:0]  nib;
  logic [1:0]  sel;
  logic        addr_hit_o, write_mode_o, stand_alone_o, output_pin_two_o, output_pin_three_o;
  logic        input_zero_pull_dn_o, input_one_pull_dn_o, input_four_pull_dn_o;
  logic        pin_two_pull_dn_o, pin_two_pull_up_o, pin_three_pull_dn_o, pin_three_pull_up_o;
  logic [7:0]  exp_q[$];
  int          num_errors = 0, checked = 0;
  wire  [6:0]  pulls = {input_zero_pull_dn_o, input_one_pull_dn_o, input_four_pull_dn_o, pin_two_pull_dn_o,
                        pin_two_pull_up_o, pin_three_pull_dn_o, pin_three_pull_up_o};
  wire         sel_pin = sel == 2'd1 ? input_pin_zero_i : sel == 2'd2 ? input_pin_one_i :
                         sel == 2'd3 & input_pin_four_i;
  pcp_config_regs #(.DEFAULT_ADDR7(7'h68), .DEVICE_CODE(DEV), .MASK_REV(4'h9), .CHIP_VARIANT(4'h6),
                    .CUSTOMER_CODE(CUST), .OTP_VARIANT(OTP)) u_pcp_config_regs (
    .core_clk_i, .rst_i, .acc_start_i, .acc_done_i, .wr_en_i, .rd_en_i, .local_addr_i, .wr_data_i,
    .four_wire_i, .slave_addr7_i, .input_pin_zero_i, .input_pin_one_i, .input_pin_four_i, .pin_two_is_out_i,
    .pin_three_is_out_i, .rega_good_i, .regb_good_i, .rega_ready_i, .regb_ready_i, .rd_data_o, .addr_hit_o,
    .addr_page_o, .full_addr_o, .write_mode_o, .input_zero_pull_dn_o, .input_one_pull_dn_o,
    .input_four_pull_dn_o, .pin_two_pull_dn_o, .pin_two_pull_up_o, .pin_three_pull_dn_o,
    .pin_three_pull_up_o, .output_pin_two_o, .output_pin_three_o, .stand_alone_o, .osc_offset_khz_o,
    .oscillator_trim_o, .active_base7_o);
  pcp_host_model u_pcp_host_model (.core_clk_i, .wr_en_o(wr_en_i), .rd_en_o(rd_en_i), .addr_o(local_addr_i),
    .data_o(wr_data_i), .acc_start_o(acc_start_i), .acc_done_o(acc_done_i));
  always #12.5 core_clk_i = ~core_clk_i;
  // ============================================================
  // Tasks
  task automatic cmp(input string what, input logic [11:0] exp, input logic [11:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_pcp_host_model.strobe(1'b1, a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_pcp_host_model.strobe(1'b0, a, 8'h00);
  endtask
  task automatic settle;
    repeat (2) @(negedge core_clk_i);
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ============================================================
  // Read watcher: data stands the cycle after the taking edge
  always @(posedge core_clk_i) rd_d1 <= rd_en_i;
  always @(negedge core_clk_i) begin
    if (rd_d1 === 1'b1) begin
      cmp("rd_data_o", {4'h0, exp_q.pop_front()}, {4'h0, rd_data_o});
    end
  end
  initial begin
    #(25 * 20000);
    num_errors++;
    stop_test;
  end
  // ============================================================
  // Tests
  initial begin
    void'($urandom(50755));
    repeat (6) @(negedge core_clk_i);
    rst_i = 1'b0;
    cmp("reset outs", 12'h000, {stand_alone_o, oscillator_trim_o, pulls, write_mode_o});
    // Page register reached through its low mirror while page is zero
    wr(8'h00, 8'h02);
    for (int a = 8'h45; a < 8'h4a; a++) rd_chk(8'(a), 8'h00);
    for (int i = 0; i < 5; i++) begin
      v = (i == 4) ? 8'h1f : 8'($urandom);
      {pin_two_is_out_i, pin_three_is_out_i} = 2'($urandom);
      wr(8'h45, v);
      rd_chk(8'h45, v & 8'h1f);
      settle;
      pe = {v[0], v[1], v[4], v[2] & ~pin_two_is_out_i, v[2] & pin_two_is_out_i, v[3] & ~pin_three_is_out_i,
            v[3] & pin_three_is_out_i};
      cmp("pulls", 12'(pe), 12'(pulls));
    end
    for (int f = 0; f < 4; f++) begin
      for (int c = 0; c < 3; c++) begin  // Reserved code left alone
        wr(8'h46, 8'(c << (2 * f)));
        rd_chk(8'h46, 8'(c << (2 * f)));
        for (int s = 0; s < 2; s++) begin
          {regb_good_i, rega_good_i, regb_ready_i, rega_ready_i} = ~(4'(1) << f) | (4'(s) << f);
          settle;
          cmp("route", {s == 1 && c == 1, s == 1 && c == 2}, {output_pin_two_o, output_pin_three_o});
        end
      end
    end
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 8'h87 : (i == 1) ? 8'h00 : 8'($urandom);
      wr(8'h47, v);
      rd_chk(8'h47, v & 8'h87);
      settle;
      cmp("osc", {v[7], 8'h00, v[2:0]}, {stand_alone_o, 8'h00, oscillator_trim_o});
      cmp("osc_khz", 12'(v[2:0]) * 12'd180, osc_offset_khz_o);
    end
    for (int i = 0; i < 8; i++) begin
      sel = 2'(i % 4);
      nib = (i > 3) ? 4'h0 : 4'($urandom_range(15, 1));
      {input_pin_zero_i, input_pin_one_i, input_pin_four_i} = (i % 2 == 1) ? 3'h7 : 3'($urandom);
      wr(8'h48, {nib, 2'b11, sel});
      rd_chk(8'h48, {nib, 2'b00, sel});
      base = (nib != 4'h0 && sel_pin) ? {nib, 3'b000} : 7'h68;
      settle;
      cmp("base", 12'(base), 12'(active_base7_o));
      for (int d = 0; d < 4; d++) begin
        slave_addr7_i = base + 7'(d);
        settle;
        cmp("hit", 12'(d < 3), 12'(addr_hit_o));
        if (d < 3) cmp("page", 12'(2 * d), 12'(addr_page_o));
      end
    end
    wr(8'h00, 8'h7c);
    rd_chk(8'h00, 8'h44);
    cmp("full_addr", 12'h200, 12'(full_addr_o));
    cmp("write_mode", 12'h001, 12'(write_mode_o));
    rd_chk(8'h01, DEV);
    rd_chk(8'h02, 8'h96);
    rd_chk(8'h03, CUST);
    wr(8'h04, ~OTP);
    rd_chk(8'h04, OTP);
    rd_chk(8'h05, 8'h00);
    four_wire_i = 1'b1;
    settle;
    cmp("pins taken", 12'h000, {input_four_pull_dn_o, pin_three_pull_dn_o, pin_three_pull_up_o, output_pin_three_o});
    rd_chk(8'h81, DEV);
    wr(8'h80, 8'h42);
    rd_chk(8'hc5, 8'h1f);
    cmp("full_addr", 12'h145, 12'(full_addr_o));
    four_wire_i = 1'b0;
    rd_chk(8'hc5, 8'h00);
    cmp("full_addr", 12'h1c5, 12'(full_addr_o));
    wr(8'h00, 8'h84);
    u_pcp_host_model.pulse(1'b0);
    rd_chk(8'h00, 8'h84);
    u_pcp_host_model.pulse(1'b1);
    settle;
    rd_chk(8'h45, 8'h00);
    cmp("full_addr", 12'h045, 12'(full_addr_o));
    settle;
    cmp("queue", 12'h000, 12'(exp_q.size()));
    stop_test;
  end
endmodule
